// file: verilog/dac_ctrl_pkg.sv
`default_nettype none
package dac_ctrl_pkg;
  // Geometry.
  localparam int NUM_CHANNELS = 8;
  localparam int MAIN_BITS    = 10;
  localparam int OFFSET_BITS  = 8;
  localparam int LEVEL_BITS   = 15;
  localparam int CH_IDX_BITS  = 3;
  localparam int ADDR_BITS    = 12;
  localparam int DATA_BITS    = 32;

  // Register byte offsets.
  localparam logic [11:0] SYSCTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET  = 12'h004;
  localparam logic [11:0] CHCTRL_BASE    = 12'h020;
  localparam logic [11:0] DATA_BASE      = 12'h040;

  // System control fields.
  localparam int SYS_STANDBY_BIT    = 4;
  localparam int SYS_SHUTDOWN_N_BIT = 5;
  localparam int SYS_FORMAT_BIT     = 6;

  // Channel control fields.
  localparam int CH_BIAS_LSB       = 0;
  localparam int CH_OFFSET_SEL_BIT = 2;
  localparam int CH_STANDBY_N_BIT  = 4;

  // Status fields.
  localparam int STAT_PENDING_BIT = 0;
  localparam int STAT_STROBE_BIT  = 1;
  localparam int STAT_REF_BIT     = 2;

  // Data register readback field.
  localparam int DATA_OFFSET_LSB = 16;

  // Reset values.
  localparam logic       SYS_SHUTDOWN_N_RST = 1'h1;
  localparam logic       SYS_STANDBY_RST    = 1'h1;
  localparam logic       SYS_FORMAT_RST     = 1'h1;
  localparam logic       CH_STANDBY_N_RST   = 1'h1;
  localparam logic       CH_OFFSET_SEL_RST  = 1'h0;
  localparam logic [1:0] CH_BIAS_RST        = 2'h0;

  // Code handling.
  localparam logic                  FORMAT_OFFSET_BINARY = 1'h1;
  localparam logic [MAIN_BITS-1:0]  MAIN_MID   = 10'h200;
  localparam logic [OFFSET_BITS-1:0] OFFSET_MID = 8'h80;
  localparam logic signed [LEVEL_BITS-1:0] MAIN_GAIN   = 15'sh00F;
  localparam logic signed [LEVEL_BITS-1:0] OFFSET_GAIN = 15'sh002;
endpackage
`default_nettype wire

// file: verilog/dac_channel_slot.sv
`timescale 1ns/1ps
`default_nettype none
module dac_channel_slot (
  input  wire logic                                     mclk,
  input  wire logic                                     rst_n,
  input  wire logic                                     ce,
  input  wire logic                                     wrEn,
  input  wire logic                                     wrOffset,
  input  wire logic [dac_ctrl_pkg::MAIN_BITS-1:0]       wrData,
  input  wire logic                                     xfer,
  input  wire logic                                     formatOffsetBinary,
  output logic [dac_ctrl_pkg::MAIN_BITS-1:0]            dataMain,
  output logic [dac_ctrl_pkg::OFFSET_BITS-1:0]          dataOffset,
  output logic [dac_ctrl_pkg::MAIN_BITS-1:0]            outMain,
  output logic [dac_ctrl_pkg::OFFSET_BITS-1:0]          outOffset,
  output logic signed [dac_ctrl_pkg::MAIN_BITS-1:0]     mainLevel,
  output logic signed [dac_ctrl_pkg::OFFSET_BITS-1:0]   offsetLevel,
  output logic signed [dac_ctrl_pkg::LEVEL_BITS-1:0]    level
);
  localparam int MB = dac_ctrl_pkg::MAIN_BITS;
  localparam int OB = dac_ctrl_pkg::OFFSET_BITS;
  localparam int LB = dac_ctrl_pkg::LEVEL_BITS;

  typedef struct packed {
    logic [MB-1:0]        dataMain;
    logic [OB-1:0]        dataOffset;
    logic [MB-1:0]        outMain;
    logic [OB-1:0]        outOffset;
    logic signed [MB-1:0] mainLevel;
    logic signed [OB-1:0] offsetLevel;
    logic signed [LB-1:0] level;
  } slot_s;

  slot_s st_r;
  slot_s st_nxt;
  logic signed [MB-1:0] mainS;
  logic signed [OB-1:0] offS;
  logic signed [LB-1:0] mainExt;
  logic signed [LB-1:0] offExt;

  always_comb begin
    st_nxt = st_r;
    if (wrEn && !wrOffset) begin
      st_nxt.dataMain = wrData;
    end
    if (wrEn && wrOffset) begin
      st_nxt.dataOffset = wrData[OB-1:0];
    end
    // The copy uses the freshly written code so a write with the strobe low
    // reaches the output in the same edge.
    if (xfer) begin
      st_nxt.outMain   = st_nxt.dataMain;
      st_nxt.outOffset = st_nxt.dataOffset;
    end
    // Offset binary becomes signed by flipping the top bit.
    mainS = formatOffsetBinary ?
            $signed(st_r.outMain ^ dac_ctrl_pkg::MAIN_MID) :
            $signed(st_r.outMain);
    offS  = formatOffsetBinary ?
            $signed(st_r.outOffset ^ dac_ctrl_pkg::OFFSET_MID) :
            $signed(st_r.outOffset);
    mainExt = LB'(mainS);
    offExt  = LB'(offS);
    st_nxt.mainLevel   = mainS;
    st_nxt.offsetLevel = offS;
    // Units of bias/8192 above the bias level.
    st_nxt.level = LB'(mainExt * dac_ctrl_pkg::MAIN_GAIN
                   + offExt * dac_ctrl_pkg::OFFSET_GAIN);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign dataMain    = st_r.dataMain;
  assign dataOffset  = st_r.dataOffset;
  assign outMain     = st_r.outMain;
  assign outOffset   = st_r.outOffset;
  assign mainLevel   = st_r.mainLevel;
  assign offsetLevel = st_r.offsetLevel;
  assign level       = st_r.level;
endmodule // dac_channel_slot
`default_nettype wire

// file: verilog/dac_lowpower_load_coding_ctrl.sv
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dac_lowpower_load_coding_ctrl #(
  parameter int NUM_CHANNELS = dac_ctrl_pkg::NUM_CHANNELS
) (
  input  wire logic                                          mclk,
  input  wire logic                                          rst_n,
  input  wire logic                                          ce,
  input  wire logic                                          psel,
  input  wire logic                                          penable,
  input  wire logic                                          pwrite,
  input  wire logic [dac_ctrl_pkg::ADDR_BITS-1:0]            paddr,
  input  wire logic [dac_ctrl_pkg::DATA_BITS-1:0]            pwdata,
  output logic [dac_ctrl_pkg::DATA_BITS-1:0]                 prdata,
  output logic                                               pready,
  output logic                                               pslverr,
  input  wire logic                                          loadOutputsN,
  output logic                                               referencePowered,
  output logic [NUM_CHANNELS-1:0]                            channelPowered,
  output logic [NUM_CHANNELS*dac_ctrl_pkg::MAIN_BITS-1:0]    mainLevel,
  output logic [NUM_CHANNELS*dac_ctrl_pkg::OFFSET_BITS-1:0]  offsetLevel,
  output logic [NUM_CHANNELS*dac_ctrl_pkg::LEVEL_BITS-1:0]   channelLevel
);
  localparam int MB = dac_ctrl_pkg::MAIN_BITS;
  localparam int OB = dac_ctrl_pkg::OFFSET_BITS;
  localparam int LB = dac_ctrl_pkg::LEVEL_BITS;
  localparam int IB = dac_ctrl_pkg::CH_IDX_BITS;
  localparam int DB = dac_ctrl_pkg::DATA_BITS;
  localparam int N  = NUM_CHANNELS;

  typedef struct packed {
    logic                 sysShutdownN;
    logic                 sysAllStandby;
    logic                 sysFormat;
    logic [N-1:0]         chStandbyN;
    logic [N-1:0]         chOffsetSel;
    logic [N-1:0][1:0]    chBias;
    logic [2:0]           strobeSync;
    logic                 strobeLevel;
    logic                 pending;
    logic                 refPowered;
    logic [N-1:0]         chPowered;
    logic                 pready;
    logic                 pslverr;
    logic [DB-1:0]        prdata;
  } ctrl_s;

  localparam ctrl_s RST_STATE = '{
    sysShutdownN:  dac_ctrl_pkg::SYS_SHUTDOWN_N_RST,
    sysAllStandby: dac_ctrl_pkg::SYS_STANDBY_RST,
    sysFormat:     dac_ctrl_pkg::SYS_FORMAT_RST,
    chStandbyN:    {N{dac_ctrl_pkg::CH_STANDBY_N_RST}},
    chOffsetSel:   {N{dac_ctrl_pkg::CH_OFFSET_SEL_RST}},
    chBias:        {N{dac_ctrl_pkg::CH_BIAS_RST}},
    strobeSync:    3'h7,
    strobeLevel:   1'h1,
    pending:       1'h0,
    refPowered:    dac_ctrl_pkg::SYS_SHUTDOWN_N_RST,
    chPowered:     '0,
    pready:        1'h0,
    pslverr:       1'h0,
    prdata:        '0
  };

  ctrl_s st_r;
  ctrl_s st_nxt;

  logic          setupPhase;
  logic          writeDone;
  logic          isSys;
  logic          isStat;
  logic          isCh;
  logic          isData;
  logic [IB-1:0] chIdx;
  logic          chInRange;
  logic          strobeFall;
  logic          xfer;
  logic [N-1:0]  dataWrEn;
  logic [N-1:0][MB-1:0] dataMainA;
  logic [N-1:0][OB-1:0] dataOffsetA;
  logic [DB-1:0] rdMux;

  always_comb begin
    st_nxt     = st_r;
    setupPhase = psel && !penable;
    writeDone  = psel && penable && st_r.pready && pwrite;
    chIdx      = paddr[IB+1:2];
    chInRange  = int'(chIdx) < N;
    isSys  = paddr == dac_ctrl_pkg::SYSCTRL_OFFSET;
    isStat = paddr == dac_ctrl_pkg::STATUS_OFFSET;
    isCh   = chInRange && paddr[1:0] == 2'h0 &&
             paddr[11:5] == dac_ctrl_pkg::CHCTRL_BASE[11:5];
    isData = chInRange && paddr[1:0] == 2'h0 &&
             paddr[11:5] == dac_ctrl_pkg::DATA_BASE[11:5];

    // The first stage feeds only the second; a level counts once the
    // second and third stages agree, which rejects a one-cycle glitch.
    st_nxt.strobeSync = {st_r.strobeSync[1:0], loadOutputsN};
    if (st_r.strobeSync[1] == st_r.strobeSync[2]) begin
      st_nxt.strobeLevel = st_r.strobeSync[2];
    end
    strobeFall = st_r.strobeLevel && !st_nxt.strobeLevel;

    // Any completed write is the sample point of the strobe.
    xfer = (writeDone && !st_r.strobeLevel) || strobeFall;
    // Set wins over the clear by the falling edge.
    st_nxt.pending = (writeDone && st_r.strobeLevel) ||
                     (st_r.pending && !strobeFall);

    if (writeDone && isSys) begin
      st_nxt.sysShutdownN  = pwdata[dac_ctrl_pkg::SYS_SHUTDOWN_N_BIT];
      st_nxt.sysAllStandby = pwdata[dac_ctrl_pkg::SYS_STANDBY_BIT];
      st_nxt.sysFormat     = pwdata[dac_ctrl_pkg::SYS_FORMAT_BIT];
    end
    if (writeDone && isCh) begin
      st_nxt.chStandbyN[chIdx]  = pwdata[dac_ctrl_pkg::CH_STANDBY_N_BIT];
      st_nxt.chOffsetSel[chIdx] = pwdata[dac_ctrl_pkg::CH_OFFSET_SEL_BIT];
      st_nxt.chBias[chIdx] = pwdata[dac_ctrl_pkg::CH_BIAS_LSB +: 2];
    end

    // Shutdown only gates power; no stored code is touched by it.
    st_nxt.refPowered = st_nxt.sysShutdownN;
    st_nxt.chPowered  = {N{st_nxt.sysShutdownN && !st_nxt.sysAllStandby}}
                        & st_nxt.chStandbyN;

    rdMux = '0;
    if (isSys) begin
      rdMux[dac_ctrl_pkg::SYS_SHUTDOWN_N_BIT] = st_r.sysShutdownN;
      rdMux[dac_ctrl_pkg::SYS_STANDBY_BIT]    = st_r.sysAllStandby;
      rdMux[dac_ctrl_pkg::SYS_FORMAT_BIT]     = st_r.sysFormat;
    end else if (isStat) begin
      rdMux[dac_ctrl_pkg::STAT_PENDING_BIT] = st_r.pending;
      rdMux[dac_ctrl_pkg::STAT_STROBE_BIT]  = st_r.strobeLevel;
      rdMux[dac_ctrl_pkg::STAT_REF_BIT]     = st_r.refPowered;
    end else if (isCh) begin
      rdMux[dac_ctrl_pkg::CH_STANDBY_N_BIT]  = st_r.chStandbyN[chIdx];
      rdMux[dac_ctrl_pkg::CH_OFFSET_SEL_BIT] = st_r.chOffsetSel[chIdx];
      rdMux[dac_ctrl_pkg::CH_BIAS_LSB +: 2]  = st_r.chBias[chIdx];
    end else if (isData) begin
      rdMux[MB-1:0] = dataMainA[chIdx];
      rdMux[dac_ctrl_pkg::DATA_OFFSET_LSB +: OB] = dataOffsetA[chIdx];
    end

    // One wait-free access phase: ready rises in the cycle after setup.
    st_nxt.pready  = setupPhase;
    st_nxt.pslverr = setupPhase && !(isSys || isCh || isData ||
                                     (isStat && !pwrite));
    st_nxt.prdata  = (setupPhase && !pwrite) ? rdMux : '0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= RST_STATE;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gChan
      assign dataWrEn[g] = writeDone && isData && chIdx == IB'(g);
      dac_channel_slot uSlot (
        .mclk               (mclk),
        .rst_n              (rst_n),
        .ce                 (ce),
        .wrEn               (dataWrEn[g]),
        .wrOffset           (st_r.chOffsetSel[g]),
        .wrData             (pwdata[MB-1:0]),
        .xfer               (xfer),
        .formatOffsetBinary (st_r.sysFormat),
        .dataMain           (dataMainA[g]),
        .dataOffset         (dataOffsetA[g]),
        .outMain            (),
        .outOffset          (),
        .mainLevel          (mainLevel[g*MB +: MB]),
        .offsetLevel        (offsetLevel[g*OB +: OB]),
        .level              (channelLevel[g*LB +: LB])
      );
    end
  endgenerate

  assign prdata           = st_r.prdata;
  assign pready           = st_r.pready;
  assign pslverr          = st_r.pslverr;
  assign referencePowered = st_r.refPowered;
  assign channelPowered   = st_r.chPowered;

  property p_shutdownOff;
    @(posedge mclk) disable iff (!rst_n)
      ce && writeDone && isSys && !pwdata[dac_ctrl_pkg::SYS_SHUTDOWN_N_BIT]
      |=> !referencePowered && channelPowered == '0;
  endproperty
  a_shutdownOff: assert property (p_shutdownOff)
    else $error("shutdown did not power everything down");

  property p_keepData;
    @(posedge mclk) disable iff (!rst_n)
      !st_r.sysShutdownN && !(writeDone && isData) |=> $stable(dataMainA);
  endproperty
  a_keepData: assert property (p_keepData)
    else $error("data lost during shutdown");

  property p_allStandby;
    @(posedge mclk) disable iff (!rst_n)
      st_r.sysAllStandby |-> channelPowered == '0 &&
                             referencePowered == st_r.sysShutdownN;
  endproperty
  a_allStandby: assert property (p_allStandby)
    else $error("all-channel standby left a channel powered");

  property p_chStandby;
    @(posedge mclk) disable iff (!rst_n)
      channelPowered == ({N{st_r.sysShutdownN && !st_r.sysAllStandby}}
                         & st_r.chStandbyN);
  endproperty
  a_chStandby: assert property (p_chStandby)
    else $error("channel power does not follow its standby bit");

  property p_deferPending;
    @(posedge mclk) disable iff (!rst_n)
      ce && writeDone && st_r.strobeLevel |=> st_r.pending;
  endproperty
  a_deferPending: assert property (p_deferPending)
    else $error("deferred write not marked pending");

  property p_fallClears;
    @(posedge mclk) disable iff (!rst_n)
      ce && strobeFall && !writeDone |=> !st_r.pending;
  endproperty
  a_fallClears: assert property (p_fallClears)
    else $error("strobe edge did not finish pending update");

  property p_strobeFilter;
    @(posedge mclk) disable iff (!rst_n)
      ce && $past(ce) && st_r.strobeSync[2:1] == 2'h0 |=> !st_r.strobeLevel;
  endproperty
  a_strobeFilter: assert property (p_strobeFilter)
    else $error("agreed strobe level not taken");

  property p_resetStandby;
    @(posedge mclk) $rose(rst_n) |-> st_r.sysAllStandby && st_r.sysFormat
                                     && referencePowered && &st_r.chStandbyN;
  endproperty
  a_resetStandby: assert property (p_resetStandby)
    else $error("wrong state after reset");

  property p_readyOne;
    @(posedge mclk) disable iff (!rst_n)
      ce && psel && !penable |=> pready ##1 (!pready || !ce);
  endproperty
  a_readyOne: assert property (p_readyOne)
    else $error("ready did not follow setup");

  // The filter holds its level while the last two stages disagree, so a
  // single-cycle glitch on the pin never starts an update.
  property p_strobeHold;
    @(posedge mclk) disable iff (!rst_n)
      ce && st_r.strobeSync[2] != st_r.strobeSync[1]
      |=> $stable(st_r.strobeLevel);
  endproperty
  a_strobeHold: assert property (p_strobeHold)
    else $error("strobe level moved before the filter agreed");

  property p_syncNoPending;
    @(posedge mclk) disable iff (!rst_n)
      ce && writeDone && !st_r.strobeLevel && !st_r.pending
      |=> !st_r.pending;
  endproperty
  a_syncNoPending: assert property (p_syncNoPending)
    else $error("synchronous write left an update pending");

  property p_formatWrite;
    @(posedge mclk) disable iff (!rst_n)
      ce && writeDone && isSys
      |=> st_r.sysFormat == $past(pwdata[dac_ctrl_pkg::SYS_FORMAT_BIT]);
  endproperty
  a_formatWrite: assert property (p_formatWrite)
    else $error("coding select not taken from the write");

  property p_formatHeld;
    @(posedge mclk) disable iff (!rst_n)
      !(ce && writeDone && isSys) |=> $stable(st_r.sysFormat);
  endproperty
  a_formatHeld: assert property (p_formatHeld)
    else $error("coding select changed without a write");

  property p_refusedErr;
    @(posedge mclk) disable iff (!rst_n)
      ce && setupPhase && !(isSys || isStat || isCh || isData)
      |=> pready && pslverr;
  endproperty
  a_refusedErr: assert property (p_refusedErr)
    else $error("unmapped access not refused");

  property p_chIsolated;
    @(posedge mclk) disable iff (!rst_n)
      ce && writeDone && isCh |=> $stable(referencePowered);
  endproperty
  a_chIsolated: assert property (p_chIsolated)
    else $error("channel control write touched the reference");
endmodule // dac_lowpower_load_coding_ctrl
`default_nettype wire

// file: test/dac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
  input  wire logic                                mclk,
  input  wire logic                                pready,
  input  wire logic [dac_ctrl_pkg::DATA_BITS-1:0]  prdata,
  input  wire logic                                pslverr,
  output logic                                     psel,
  output logic                                     penable,
  output logic                                     pwrite,
  output logic [dac_ctrl_pkg::ADDR_BITS-1:0]       paddr,
  output logic [dac_ctrl_pkg::DATA_BITS-1:0]       pwdata,
  output logic                                     loadOutputsN
);
  logic [dac_ctrl_pkg::DATA_BITS-1:0] rdData;
  logic                               rdErr;

  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    loadOutputsN = 1'h1;
    rdData = 32'h0;
    rdErr = 1'h0;
  end

  // The address alone tells data writes from control writes.
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // A low level held for good gives synchronous updates; the two idle
  // edges first give the strobe its setup time after a write.
  task automatic setStrobe(input logic v);
    repeat (2) @(posedge mclk);
    loadOutputsN <= v;
    // The pin passes a three-stage filter before the block sees it.
    repeat (4) @(posedge mclk);
  endtask
endmodule // dac_host_model
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int NCH = dac_ctrl_pkg::NUM_CHANNELS;
  logic                 mclk;
  logic                 rst_n;
  logic                 ce;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 loadOutputsN;
  logic                 referencePowered;
  logic [NCH-1:0]       channelPowered;
  logic [NCH*10-1:0]    mainLevel;
  logic [NCH*8-1:0]     offsetLevel;
  logic [NCH*15-1:0]    channelLevel;
  logic [9:0]           mExp [NCH];
  logic [7:0]           oExp [NCH];
  logic                 fmtOb;
  int                   n_fail;
  int                   num_checks;
  integer               seed;

  always #5 mclk = ~mclk;

  dac_lowpower_load_coding_ctrl #(.NUM_CHANNELS(NCH)) dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .loadOutputsN(loadOutputsN),
    .referencePowered(referencePowered), .channelPowered(channelPowered),
    .mainLevel(mainLevel), .offsetLevel(offsetLevel),
    .channelLevel(channelLevel));

  dac_host_model host (
    .mclk(mclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .loadOutputsN(loadOutputsN));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Signed value of a code of width w under the selected coding.
  function automatic int code2int(input logic [9:0] c, input int w,
                                  input logic ob);
    int v;
    v = int'(c);
    if (ob) v = v - (1 << (w - 1));
    else if (c[w-1]) v = v - (1 << w);
    return v;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'h1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    host.xfer(1'h0, a, 32'h0);
  endtask

  task automatic checkCh(input int ch);
    int a;
    int b;
    a = code2int(mExp[ch], 10, fmtOb);
    b = code2int({2'h0, oExp[ch]}, 8, fmtOb);
    chk(32'(mainLevel[ch*10+:10]), {22'h0, 10'(a)});
    chk(32'(offsetLevel[ch*8+:8]), {24'h0, 8'(b)});
    chk(32'(channelLevel[ch*15+:15]), {17'h0, 15'(15*a+2*b)});
  endtask

  // Offset code first, then the main code, so both reach the channel.
  task automatic loadCh(input int ch, input logic [9:0] m,
                        input logic [7:0] o);
    wr(dac_ctrl_pkg::CHCTRL_BASE + 12'(4*ch), 32'h014);
    wr(dac_ctrl_pkg::DATA_BASE + 12'(4*ch), 32'(o));
    wr(dac_ctrl_pkg::CHCTRL_BASE + 12'(4*ch), 32'h011);
    wr(dac_ctrl_pkg::DATA_BASE + 12'(4*ch), 32'(m));
    mExp[ch] = m;
    oExp[ch] = o;
    rd(dac_ctrl_pkg::DATA_BASE + 12'(4*ch));
    chk(host.rdData & 32'h00FF03FF, {8'h0, o, 6'h0, m});
  endtask

  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  initial begin
    seed = 92055;
    mclk = 1'h0;
    rst_n = 1'h0;
    ce = 1'h1;
    n_fail = 0;
    num_checks = 0;
    fmtOb = 1'h1;
    for (int i = 0; i < NCH; i++) begin
      mExp[i] = 10'h000;
      oExp[i] = 8'h00;
    end
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    chk(32'(referencePowered), 32'h1);
    chk(32'(channelPowered), 32'h0);
    rd(dac_ctrl_pkg::SYSCTRL_OFFSET);
    chk(host.rdData & 32'h70, 32'h70);
    rd(dac_ctrl_pkg::CHCTRL_BASE);
    chk(host.rdData & 32'h17, 32'h10);
    $display("test reset done");
    host.setStrobe(1'h0);
    repeat (4) @(posedge mclk);
    for (int f = 1; f >= 0; f--) begin
      fmtOb = 1'(f);
      wr(dac_ctrl_pkg::SYSCTRL_OFFSET, f ? 32'h060 : 32'h020);
      for (int ch = 0; ch < NCH; ch++) begin
        loadCh(ch, 10'($random(seed)), 8'($random(seed)));
      end
      loadCh(0, 10'h200, 8'h80);
      loadCh(1, 10'h1FF, 8'h7F);
      repeat (3) @(posedge mclk);
      chk(32'(channelPowered), 32'(8'hFF));
      for (int ch = 0; ch < NCH; ch++) checkCh(ch);
      $display("test coding format %0d done", f);
    end
    host.setStrobe(1'h1);
    wr(dac_ctrl_pkg::DATA_BASE + 12'h008, 32'h155);
    repeat (3) @(posedge mclk);
    checkCh(2);
    rd(dac_ctrl_pkg::STATUS_OFFSET);
    chk(host.rdData & 32'h7, 32'h7);
    host.setStrobe(1'h0);
    repeat (6) @(posedge mclk);
    mExp[2] = 10'h155;
    checkCh(2);
    rd(dac_ctrl_pkg::STATUS_OFFSET);
    chk(host.rdData & 32'h7, 32'h4);
    $display("test deferred update done");
    wr(dac_ctrl_pkg::CHCTRL_BASE + 12'h00C, 32'h001);
    repeat (2) @(posedge mclk);
    chk(32'(channelPowered), 32'(8'hF7));
    chk(32'(referencePowered), 32'h1);
    wr(dac_ctrl_pkg::CHCTRL_BASE + 12'h00C, 32'h011);
    wr(dac_ctrl_pkg::SYSCTRL_OFFSET, 32'h030);
    repeat (2) @(posedge mclk);
    chk(32'(channelPowered), 32'h0);
    chk(32'(referencePowered), 32'h1);
    wr(dac_ctrl_pkg::SYSCTRL_OFFSET, 32'h000);
    repeat (2) @(posedge mclk);
    chk(32'(channelPowered), 32'h0);
    chk(32'(referencePowered), 32'h0);
    rd(dac_ctrl_pkg::DATA_BASE + 12'h010);
    chk(host.rdData & 32'h00FF03FF, {8'h0, oExp[4], 6'h0, mExp[4]});
    wr(dac_ctrl_pkg::SYSCTRL_OFFSET, 32'h020);
    repeat (3) @(posedge mclk);
    chk(32'(referencePowered), 32'h1);
    chk(32'(channelPowered), 32'(8'hFF));
    checkCh(4);
    $display("test power modes done");
    wr(12'h060, 32'h3FF);
    chk(32'(host.rdErr), 32'h1);
    wr(dac_ctrl_pkg::STATUS_OFFSET, 32'h7);
    chk(32'(host.rdErr), 32'h1);
    repeat (3) @(posedge mclk);
    for (int ch = 0; ch < NCH; ch++) checkCh(ch);
    $display("test refused access done");
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
